// ---- include/dac_pkg.sv ----
`default_nettype none
package dac_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] SRC_LO_OFS = 12'h0B0;
   localparam logic [11:0] SRC_HI_OFS = 12'h0B4;
   localparam logic [11:0] DST_LO_OFS = 12'h0B8;
   localparam logic [11:0] DST_HI_OFS = 12'h0BC;
   localparam logic [11:0] CTL_LO_OFS = 12'h0C8;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] CTL_RESET = 32'h0206_1201;
   localparam logic [31:0] RSVD_READ = 32'h0000_0000;

   // ------------------------------------------------------------
   // control word field positions
   // ------------------------------------------------------------
   localparam int TYPE_LSB = 20;
   localparam int SRC_BURST_LSB = 14;
   localparam int DST_BURST_LSB = 11;
   localparam int SRC_STEP_LSB = 9;
   localparam int DST_STEP_LSB = 7;
   localparam int SRC_WIDTH_LSB = 4;
   localparam int DST_WIDTH_LSB = 1;

   // ------------------------------------------------------------
   // field encodings
   // ------------------------------------------------------------
   localparam logic [1:0] STEP_INC = 2'h0;
   localparam logic [1:0] STEP_DEC = 2'h1;
   localparam logic [2:0] WIDTH_MAX = 3'h2;
   localparam logic [2:0] TYPE_M2M = 3'h0;
   localparam logic [2:0] TYPE_M2P = 3'h1;
   localparam logic [2:0] TYPE_P2M = 3'h2;
   localparam logic [2:0] TYPE_P2P = 3'h3;
   localparam logic [2:0] TYPE_P2M_PF = 3'h4;
   localparam logic [2:0] TYPE_P2P_SF = 3'h5;
   localparam logic [2:0] TYPE_M2P_PF = 3'h6;
   localparam logic [2:0] TYPE_P2P_DF = 3'h7;
   localparam logic [8:0] BURST_ONE = 9'h001;
   localparam logic [8:0] BURST_BASE = 9'h002;

   typedef enum logic [1:0] {DAC_FLOW_DMA, DAC_FLOW_SRC, DAC_FLOW_DST} dac_flow_t;
   typedef enum logic {DAC_IDLE, DAC_RUN} dac_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [2:0] size;
   } dac_item_t;

   // items per burst: 1, then 4 doubling up to 256
   function automatic logic [8:0] dac_burst_len(input logic [2:0] code);
      dac_burst_len = (code == 3'h0) ? BURST_ONE : 9'(BURST_BASE << code);
   endfunction : dac_burst_len

endpackage : dac_pkg

`default_nettype wire

// ---- design/dac_channel.sv ----
`timescale 1ns/10ps
`default_nettype none

// How it works
// - source pointer steps after every source item
// - destination pointer steps after every destination item
// - type codes 000-011 keep flow with DMA
// - codes 100-111 give flow to peripheral
// - source request reads one burst of items
// - destination request writes one burst of items
// - burst code 000 is 1, else 4 doubling
// - source step 00 up, 01 down, 1x fixed
// - destination step 00 up, 01 down, 1x fixed
module dac_channel (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   // register bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // burst requests from handshaking
   input wire logic SRC_REQ,
   input wire logic DST_REQ,
   // item requests toward the bus master
   output dac_pkg::dac_item_t SRC_ITEM,
   output logic SRC_VALID,
   input wire logic SRC_READY,
   output dac_pkg::dac_item_t DST_ITEM,
   output logic DST_VALID,
   input wire logic DST_READY,
   // status
   output logic SRC_DONE,
   output logic DST_DONE,
   output logic SRC_IS_PERIPH,
   output logic DST_IS_PERIPH,
   output dac_pkg::dac_flow_t FLOW_CTL
);

   // ------------------------------------------------------------
   // register bus decode
   // ------------------------------------------------------------
   logic [31:0] ctl_word;
   logic [31:0] ptr [2];
   logic [2:0] xfer_type_flow_select;
   logic [2:0] burst_code [2];
   logic [1:0] step_mode [2];
   logic [2:0] item_width [2];
   logic req [2];
   logic ready [2];
   logic valid [2];
   logic done [2];
   logic sw_wr_ptr [2];
   logic wr_en;
   logic setup;
   logic hit;

   assign setup = CE && PSEL && !PENABLE;
   assign wr_en = CE && PSEL && PENABLE && PWRITE;
   assign hit = (PADDR == dac_pkg::SRC_LO_OFS) || (PADDR == dac_pkg::SRC_HI_OFS) ||
                (PADDR == dac_pkg::DST_LO_OFS) || (PADDR == dac_pkg::DST_HI_OFS) ||
                (PADDR == dac_pkg::CTL_LO_OFS);
   // frozen clock enable holds the access phase open
   assign PREADY = CE;
   assign PSLVERR = PSEL && PENABLE && !hit;
   assign sw_wr_ptr[0] = wr_en && (PADDR == dac_pkg::SRC_LO_OFS);
   assign sw_wr_ptr[1] = wr_en && (PADDR == dac_pkg::DST_LO_OFS);

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         ctl_word <= dac_pkg::CTL_RESET;
      else if (wr_en && PADDR == dac_pkg::CTL_LO_OFS)
         ctl_word <= PWDATA;
   end

   // read data sampled in setup; pointers may move before access
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         PRDATA <= dac_pkg::RSVD_READ;
      else if (setup)
      begin
         case (PADDR)
            dac_pkg::SRC_LO_OFS: PRDATA <= ptr[0];
            dac_pkg::DST_LO_OFS: PRDATA <= ptr[1];
            dac_pkg::CTL_LO_OFS: PRDATA <= ctl_word;
            default: PRDATA <= dac_pkg::RSVD_READ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // control field decode
   // ------------------------------------------------------------
   assign xfer_type_flow_select = ctl_word[dac_pkg::TYPE_LSB +: 3];
   assign burst_code[0] = ctl_word[dac_pkg::SRC_BURST_LSB +: 3];
   assign burst_code[1] = ctl_word[dac_pkg::DST_BURST_LSB +: 3];
   assign step_mode[0] = ctl_word[dac_pkg::SRC_STEP_LSB +: 2];
   assign step_mode[1] = ctl_word[dac_pkg::DST_STEP_LSB +: 2];
   assign item_width[0] = ctl_word[dac_pkg::SRC_WIDTH_LSB +: 3];
   assign item_width[1] = ctl_word[dac_pkg::DST_WIDTH_LSB +: 3];

   always_comb
   begin
      SRC_IS_PERIPH = 1'b1;
      DST_IS_PERIPH = 1'b1;
      case (xfer_type_flow_select)
         dac_pkg::TYPE_M2M: {SRC_IS_PERIPH, DST_IS_PERIPH} = 2'h0;
         dac_pkg::TYPE_M2P, dac_pkg::TYPE_M2P_PF: SRC_IS_PERIPH = 1'b0;
         dac_pkg::TYPE_P2M, dac_pkg::TYPE_P2M_PF: DST_IS_PERIPH = 1'b0;
         default: {SRC_IS_PERIPH, DST_IS_PERIPH} = 2'h3;
      endcase
      // top bit hands flow away; bit 1 picks destination side
      if (!xfer_type_flow_select[2])
         FLOW_CTL = dac_pkg::DAC_FLOW_DMA;
      else if (xfer_type_flow_select[1])
         FLOW_CTL = dac_pkg::DAC_FLOW_DST;
      else
         FLOW_CTL = dac_pkg::DAC_FLOW_SRC;
   end

   // ------------------------------------------------------------
   // source and destination engines
   // ------------------------------------------------------------
   assign req[0] = SRC_REQ;
   assign req[1] = DST_REQ;
   assign ready[0] = SRC_READY;
   assign ready[1] = DST_READY;

   for (genvar g = 0; g < 2; g++)
   begin : g_side
      dac_pkg::dac_state_t state;
      logic [8:0] remaining;
      logic [1:0] wsel;
      logic [31:0] step;
      logic take;

      // widths beyond 32 bits are illegal; clamp the stride
      assign wsel = (item_width[g] > dac_pkg::WIDTH_MAX) ? 2'h2 : item_width[g][1:0];
      assign step = 32'h1 << wsel;
      assign valid[g] = (state == dac_pkg::DAC_RUN);
      assign take = CE && valid[g] && ready[g];

      // requests during a running burst are dropped
      always_ff @(posedge CLK or negedge ARST_N)
      begin
         if (!ARST_N)
         begin
            state <= dac_pkg::DAC_IDLE;
            remaining <= 9'h000;
         end
         else if (CE)
         begin
            case (state)
               dac_pkg::DAC_IDLE:
                  if (req[g])
                  begin
                     state <= dac_pkg::DAC_RUN;
                     remaining <= dac_pkg::dac_burst_len(burst_code[g]);
                  end
               dac_pkg::DAC_RUN:
                  if (ready[g])
                  begin
                     remaining <= remaining - 9'h001;
                     if (remaining == 9'h001)
                        state <= dac_pkg::DAC_IDLE;
                  end
               default: state <= dac_pkg::DAC_IDLE;
            endcase
         end
      end

      always_ff @(posedge CLK or negedge ARST_N)
      begin
         if (!ARST_N)
            done[g] <= 1'b0;
         else if (CE)
            done[g] <= take && (remaining == 9'h001);
      end

      // software write beats a simultaneous step
      always_ff @(posedge CLK or negedge ARST_N)
      begin
         if (!ARST_N)
            ptr[g] <= dac_pkg::ADDR_RESET;
         else if (CE && sw_wr_ptr[g])
            ptr[g] <= PWDATA;
         else if (take)
         begin
            case (step_mode[g])
               dac_pkg::STEP_INC: ptr[g] <= ptr[g] + step;
               dac_pkg::STEP_DEC: ptr[g] <= ptr[g] - step;
               default: ptr[g] <= ptr[g];
            endcase
         end
      end
   end

   assign SRC_VALID = valid[0];
   assign DST_VALID = valid[1];
   assign SRC_ITEM = '{addr: ptr[0], size: item_width[0]};
   assign DST_ITEM = '{addr: ptr[1], size: item_width[1]};
   assign SRC_DONE = done[0];
   assign DST_DONE = done[1];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence src_take_s;
      CE && SRC_VALID && SRC_READY && !sw_wr_ptr[0];
   endsequence
   sequence dst_take_s;
      CE && DST_VALID && DST_READY && !sw_wr_ptr[1];
   endsequence

   src_step_up_a: assert property (src_take_s and step_mode[0] == dac_pkg::STEP_INC |=>
      ptr[0] == $past(ptr[0]) + $past(g_side[0].step)) else $error("source pointer not incremented");
   src_fixed_a: assert property (src_take_s and step_mode[0][1] |=> $stable(ptr[0]))
      else $error("fixed source pointer moved");
   src_step_down_a: assert property (src_take_s and step_mode[0] == dac_pkg::STEP_DEC |=>
      ptr[0] == $past(ptr[0]) - $past(g_side[0].step)) else $error("source pointer not decremented");
   dst_step_down_a: assert property (dst_take_s and step_mode[1] == dac_pkg::STEP_DEC |=>
      ptr[1] == $past(ptr[1]) - $past(g_side[1].step)) else $error("dest pointer not decremented");
   dst_idle_hold_a: assert property (!DST_VALID && !sw_wr_ptr[1] |=> $stable(ptr[1]))
      else $error("dest pointer moved without a transfer");
   src_burst_one_a: assert property (CE && !SRC_VALID && SRC_REQ && burst_code[0] == 3'h0
      ##1 CE && SRC_READY |=> !SRC_VALID && SRC_DONE) else $error("single source burst wrong");
   dst_burst_len_a: assert property (CE && !DST_VALID && DST_REQ |=>
      g_side[1].remaining == dac_pkg::dac_burst_len($past(burst_code[1])))
      else $error("dest burst length wrong");
   burst_decode_a: assert property (CE && !SRC_VALID && SRC_REQ |=>
      g_side[0].remaining == 9'h001 << (4'($past(burst_code[0])) +
      4'($past(burst_code[0]) != 3'h0))) else $error("source burst decode wrong");
   flow_dma_a: assert property (!xfer_type_flow_select[2] |-> FLOW_CTL == dac_pkg::DAC_FLOW_DMA)
      else $error("flow not with engine");
   flow_periph_a: assert property (xfer_type_flow_select == dac_pkg::TYPE_P2P_DF |->
      FLOW_CTL == dac_pkg::DAC_FLOW_DST && SRC_IS_PERIPH && DST_IS_PERIPH)
      else $error("destination flow decode wrong");
   rsvd_read_a: assert property (setup && (PADDR == dac_pkg::SRC_HI_OFS ||
      PADDR == dac_pkg::DST_HI_OFS) |=> PRDATA == dac_pkg::RSVD_READ)
      else $error("reserved word not zero");

endmodule : dac_channel

`default_nettype wire

// ---- tb/dac_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none
// far-side master: takes items at once, or every other cycle when slow
module dac_far_end (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // item handshakes
   input wire logic slow,
   input wire logic src_valid,
   input wire logic dst_valid,
   output logic src_ready,
   output logic dst_ready,
   // items taken so far
   output int src_taken,
   output int dst_taken
);
   logic ph;
   assign src_ready = !slow | ph;
   assign dst_ready = !slow | !ph;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ph <= 1'h0;
         src_taken <= 0;
         dst_taken <= 0;
      end
      else
      begin
         ph <= !ph;
         src_taken <= src_taken + int'(src_valid & src_ready);
         dst_taken <= dst_taken + int'(dst_valid & dst_ready);
      end
   end
endmodule : dac_far_end
`default_nettype wire

// ---- tb/dma_channel_addr_ctl_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module dma_channel_addr_ctl_tb_top;
   logic CLK = 0, ARST_N = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic SRC_REQ = 0, DST_REQ = 0, slow = 0, err;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, SRC_VALID, DST_VALID, SRC_READY, DST_READY;
   logic SRC_DONE, DST_DONE, SRC_IS_PERIPH, DST_IS_PERIPH;
   dac_pkg::dac_item_t SRC_ITEM, DST_ITEM;
   dac_pkg::dac_flow_t FLOW_CTL;
   int fail_count = 0, comparisons = 0, cyc = 0, seed = 32'h2faf;
   int st, dt, ks = 0, kd = 0, ns, nd, s0, d0;
   localparam logic [7:0] SPM = 8'hBC, DPM = 8'hEA;
   localparam logic [11:0] OFS [5] = '{dac_pkg::SRC_LO_OFS, dac_pkg::SRC_HI_OFS,
      dac_pkg::DST_LO_OFS, dac_pkg::DST_HI_OFS, dac_pkg::CTL_LO_OFS};
   localparam logic [31:0] MK [5] = '{32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF};
   dac_channel uut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SRC_REQ(SRC_REQ), .DST_REQ(DST_REQ), .SRC_ITEM(SRC_ITEM),
      .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY), .DST_ITEM(DST_ITEM),
      .DST_VALID(DST_VALID), .DST_READY(DST_READY), .SRC_DONE(SRC_DONE), .DST_DONE(DST_DONE),
      .SRC_IS_PERIPH(SRC_IS_PERIPH), .DST_IS_PERIPH(DST_IS_PERIPH), .FLOW_CTL(FLOW_CTL));
   dac_far_end far (.clk(CLK), .arst_n(ARST_N), .slow(slow), .src_valid(SRC_VALID),
      .dst_valid(DST_VALID), .src_ready(SRC_READY), .dst_ready(DST_READY),
      .src_taken(st), .dst_taken(dt));
   initial
   begin
      forever #25 CLK = ~CLK;
   end
   task test_done();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   // bounded by the overall cycle ceiling, not per wait
   always @(posedge CLK)
   begin
      cyc++;
      ks += int'(SRC_DONE === 1'h1);
      kd += int'(DST_DONE === 1'h1);
      if (cyc == 60000)
      begin
         fail_count++;
         test_done();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'h1;
      do @(posedge CLK); while (PREADY !== 1'h1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge CLK);
   endtask : apb
   function automatic logic [31:0] nxt(input logic [31:0] a, input logic [1:0] s,
      input logic [2:0] w, input int n);
      logic [31:0] k;
      k = ((w > 3'h2) ? 32'h4 : (32'h1 << w)) * n;
      nxt = (s == 2'h0) ? a + k : (s == 2'h1) ? a - k : a;
   endfunction : nxt
   function automatic int blen(input logic [2:0] c);
      blen = (c == 3'h0) ? 1 : 2 << c;
   endfunction : blen
   task burst(input logic [2:0] sb, db, input logic [1:0] ss, ds, input logic [2:0] sw, dw);
      logic [31:0] sa, da;
      sa = $random(seed);
      da = $random(seed);
      apb(1'h1, dac_pkg::SRC_LO_OFS, sa);
      apb(1'h1, dac_pkg::DST_LO_OFS, da);
      apb(1'h1, dac_pkg::CTL_LO_OFS, {9'h0, 3'h1, 3'h0, sb, db, ss, ds, sw, dw, 1'h0});
      chk(SRC_ITEM.addr, sa, "source item address");
      chk(DST_ITEM.addr, da, "dest item address");
      chk({SRC_ITEM.size, DST_ITEM.size}, {sw, dw}, "item widths");
      ns = st;
      nd = dt;
      s0 = ks;
      d0 = kd;
      SRC_REQ <= 1'h1;
      DST_REQ <= 1'h1;
      // second cycle of request lands while running and must not queue
      repeat (2) @(posedge CLK);
      SRC_REQ <= 1'h0;
      DST_REQ <= 1'h0;
      while (ks == s0 || kd == d0) @(posedge CLK);
      repeat (2) @(posedge CLK);
      chk(st - ns, blen(sb), "source item count");
      chk(dt - nd, blen(db), "dest item count");
      apb(1'h0, dac_pkg::SRC_LO_OFS, 32'h0);
      chk(rd, nxt(sa, ss, sw, blen(sb)), "source pointer");
      apb(1'h0, dac_pkg::DST_LO_OFS, 32'h0);
      chk(rd, nxt(da, ds, dw, blen(db)), "dest pointer");
      chk(SRC_ITEM.addr, nxt(sa, ss, sw, blen(sb)), "source item end");
      chk(DST_ITEM.addr, nxt(da, ds, dw, blen(db)), "dest item end");
   endtask : burst
   initial
   begin
      logic [31:0] d;
      repeat (4) @(posedge CLK);
      ARST_N <= 1'h1;
      @(posedge CLK);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'h0, OFS[i], 32'h0);
         chk(rd, (i == 4) ? dac_pkg::CTL_RESET : dac_pkg::ADDR_RESET, "reset value");
         d = $random(seed);
         apb(1'h1, OFS[i], d);
         apb(1'h0, OFS[i], 32'h0);
         chk(rd, d & MK[i], "readback");
         chk(err, 1'h0, "error on mapped");
      end
      apb(1'h1, 12'h0C0, 32'h1);
      chk(err, 1'h1, "no error on unmapped");
      for (int t = 0; t < 8; t++)
      begin
         apb(1'h1, dac_pkg::CTL_LO_OFS, 32'(t) << dac_pkg::TYPE_LSB);
         chk(32'(FLOW_CTL), t < 4 ? 32'(dac_pkg::DAC_FLOW_DMA) : t < 6 ?
            32'(dac_pkg::DAC_FLOW_SRC) : 32'(dac_pkg::DAC_FLOW_DST), "flow");
         chk({SRC_IS_PERIPH, DST_IS_PERIPH}, {SPM[t], DPM[t]}, "periph flags");
      end
      burst(3'h0, 3'h7, 2'h0, 2'h1, 3'h2, 3'h3);
      slow <= 1'h1;
      burst(3'h7, 3'h0, 2'h2, 2'h3, 3'h0, 3'h1);
      burst(3'h3, 3'h1, 2'h1, 2'h0, 3'h1, 3'h0);
      repeat (8)
      begin
         slow <= 1'($random(seed));
         burst(3'($random(seed)), 3'($random(seed)), 2'($random(seed)), 2'($random(seed)),
            3'($random(seed)), 3'($random(seed)));
      end
      test_done();
   end
endmodule : dma_channel_addr_ctl_tb_top
`default_nettype wire
